// ---- pkg/itb_defs.vh ----
// Constants for the I2C timeout and boot timer block
`ifndef ITB_DEFS_VH
`define ITB_DEFS_VH

// Register byte addresses
`define ITB_ADDR_W 17
`define ITB_OFF_TIMEOUT 17'h1d358
`define ITB_OFF_TIMER 17'h1d35c
`define ITB_OFF_STATUS 17'h1d360
`define ITB_OFF_REMAIN 17'h1d364

// Timeout register fields
`define ITB_BYTE_MSB 31
`define ITB_BYTE_LSB 16
`define ITB_TRAN_MSB 15
`define ITB_TRAN_LSB 0
`define ITB_TIMEOUT_RST 32'h00000000

// Timer register fields
`define ITB_AUTO_BIT 31
`define ITB_COUNT_MSB 15
`define ITB_COUNT_LSB 0
`define ITB_AUTO_RST 1'b0
`define ITB_COUNT_RST 16'h0fa0

// Status register bits
`define ITB_ST_BYTE 0
`define ITB_ST_TRAN 1
`define ITB_ST_GEN 2
`define ITB_ST_BOOT 3
`define ITB_ST_RUN 8
`define ITB_ST_FLAGS 4

// Timebase
`define ITB_CLK_NS 25
`define ITB_US_TICK_NS 1000
// Sized so both divider parameters take them without truncation
`define ITB_US_CYCLES 16'h0028
`define ITB_MS_TICK_US 16'h03e8

`endif

// ---- hw/itb_tick_div.v ----
// Microsecond and millisecond tick dividers
`include "itb_defs.vh"

module itb_tick_div #(
  parameter [15:0] US_CYCLES = `ITB_US_CYCLES,
  parameter [15:0] MS_TICKS = `ITB_MS_TICK_US
) (
  input wire pclk,
  input wire presetn,
  output reg microsecond_tick,
  output reg millisecond_tick
);

  reg [15:0] us_cnt;
  reg [15:0] ms_cnt;

  // Two cascaded stages keep each counter short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_cnt <= 16'h0000;
      ms_cnt <= 16'h0000;
      microsecond_tick <= 1'b0;
      millisecond_tick <= 1'b0;
    end else begin
      microsecond_tick <= 1'b0;
      millisecond_tick <= 1'b0;
      if (us_cnt == US_CYCLES - 16'h0001) begin
        us_cnt <= 16'h0000;
        microsecond_tick <= 1'b1;
        if (ms_cnt == MS_TICKS - 16'h0001) begin
          ms_cnt <= 16'h0000;
          millisecond_tick <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 16'h0001;
        end
      end else begin
        us_cnt <= us_cnt + 16'h0001;
      end
    end
  end

endmodule // itb_tick_div

// ---- hw/itb_interval_timer.v ----
// Interval watchdog counting ticks against a programmed limit
module itb_interval_timer (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire start,
  input wire stop,
  input wire [15:0] limit,
  output reg expired
);

  reg armed;
  reg [15:0] cnt;

  // Stop beats start so a closing event never re-arms
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      cnt <= 16'h0000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        armed <= 1'b0;
        cnt <= 16'h0000;
      end else if (start) begin
        armed <= 1'b1;
        cnt <= 16'h0000;
      end else if (armed && tick && limit != 16'h0000) begin
        if (cnt == limit - 16'h0001) begin
          expired <= 1'b1;
          armed <= 1'b0;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end

endmodule // itb_interval_timer

// ---- hw/itb_top.v ----
// I2C byte/transaction timeouts and boot/general timer with APB access
`include "itb_defs.vh"

// Overview of operation
// [RULE_01] The byte watchdog covers start to ack, ack to ack, ack to stop.
// [RULE_02] A byte count of zero switches the byte watchdog off.
// [RULE_03] The byte limit is the upper count field times the us tick.
// [RULE_04] The transaction watchdog runs start to stop; zero disables it.
// [RULE_05] The transaction limit is the lower count times the ms tick.
// [RULE_06] Both watchdogs reset to zero and are idle during boot load.
// [RULE_07] Auto reload clear stops the timer at expiry, set reloads it.
// [RULE_08] A timer count of zero disables it; otherwise it is general use.
// [RULE_09] The timer period is its 16-bit count times the ms tick.
// [RULE_10] Writing the timer register starts the timer.
// [RULE_11] A write while running restarts it with no expiry event.
// [RULE_12] Expiry in boot load gives the boot event, else the general one.
// [RULE_13] Auto reload still raises the event at every expiry.
// [RULE_14] The count resets to 4000 ms and so bounds the boot load.
// [RULE_15] Boot load finishing early clears the count, stopping the timer.
// [RULE_16] A watchdog expiry aborts the transfer and sets a sticky flag.
module itb_top #(
  parameter [15:0] MS_TICKS = `ITB_MS_TICK_US
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ITB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire i2c_start,
  input wire i2c_restart,
  input wire i2c_ack,
  input wire i2c_stop,
  input wire boot_active,
  input wire boot_done,
  output reg i2c_abort,
  output reg byte_timeout_event,
  output reg transaction_timeout_event,
  output reg general_timer_expired_event,
  output reg boot_load_expired_event,
  output reg timer_running
);

  // Address compare used by both decode paths
  function addr_is;
    input [`ITB_ADDR_W-1:0] a;
    input [`ITB_ADDR_W-1:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  wire microsecond_tick;
  wire millisecond_tick;
  wire byte_expired;
  wire tran_expired;

  reg [15:0] byte_limit_count;
  reg [15:0] transaction_limit_count;
  reg auto_reload;
  reg [15:0] timer_count;
  reg [15:0] remain;
  reg [`ITB_ST_FLAGS-1:0] sticky;

  // APB handshake terms
  wire access = psel & penable;
  wire done = access & pready;
  wire wr = done & pwrite;
  wire hit_timeout = addr_is(paddr, `ITB_OFF_TIMEOUT);
  wire hit_timer = addr_is(paddr, `ITB_OFF_TIMER);
  wire hit_status = addr_is(paddr, `ITB_OFF_STATUS);
  wire hit_remain = addr_is(paddr, `ITB_OFF_REMAIN);
  wire mapped = hit_timeout | hit_timer | hit_status | hit_remain;
  wire wr_timer = wr & hit_timer;

  // Timer expiry, suppressed by a restarting write in the same cycle
  wire timer_fire = timer_running & millisecond_tick &
                    (remain == 16'h0001) & ~wr_timer; // [RULE_11]

  itb_tick_div #(
    .US_CYCLES(`ITB_US_CYCLES),
    .MS_TICKS(MS_TICKS)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .microsecond_tick(microsecond_tick),
    .millisecond_tick(millisecond_tick)
  );

  // Byte watchdog: restarted at start, each ack and a repeated start
  itb_interval_timer u_byte (
    .pclk(pclk),
    .presetn(presetn),
    .tick(microsecond_tick), // [RULE_03]
    .start(i2c_start | i2c_ack | i2c_restart), // [RULE_01]
    .stop(i2c_stop | boot_active | i2c_abort), // [RULE_06]
    .limit(byte_limit_count), // [RULE_02]
    .expired(byte_expired)
  );

  // Transaction watchdog: a repeated start does not restart it
  itb_interval_timer u_tran (
    .pclk(pclk),
    .presetn(presetn),
    .tick(millisecond_tick), // [RULE_05]
    .start(i2c_start), // [RULE_04]
    .stop(i2c_stop | boot_active | i2c_abort), // [RULE_06]
    .limit(transaction_limit_count), // [RULE_04]
    .expired(tran_expired)
  );

  // APB answers one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata <= 32'h00000000;
      if (access & ~pready & ~pwrite) begin
        if (hit_timeout) begin
          prdata <= {byte_limit_count, transaction_limit_count};
        end else if (hit_timer) begin
          prdata <= {auto_reload, 15'h0000, timer_count};
        end else if (hit_status) begin
          prdata <= {23'h000000, timer_running, 4'h0, sticky};
        end else if (hit_remain) begin
          prdata <= {16'h0000, remain};
        end
      end
    end
  end

  // Watchdog limits, zero after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_limit_count <= 16'h0000; // [RULE_06]
      transaction_limit_count <= 16'h0000; // [RULE_06]
    end else if (wr & hit_timeout) begin
      byte_limit_count <= pwdata[`ITB_BYTE_MSB:`ITB_BYTE_LSB];
      transaction_limit_count <= pwdata[`ITB_TRAN_MSB:`ITB_TRAN_LSB];
    end
  end

  // Boot/general timer; running from reset so it bounds boot load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_reload <= `ITB_AUTO_RST;
      timer_count <= `ITB_COUNT_RST; // [RULE_14]
      remain <= `ITB_COUNT_RST; // [RULE_14]
      timer_running <= 1'b1; // [RULE_14]
    end else if (wr_timer) begin
      auto_reload <= pwdata[`ITB_AUTO_BIT];
      timer_count <= pwdata[`ITB_COUNT_MSB:`ITB_COUNT_LSB]; // [RULE_10]
      remain <= pwdata[`ITB_COUNT_MSB:`ITB_COUNT_LSB]; // [RULE_11]
      timer_running <=
        pwdata[`ITB_COUNT_MSB:`ITB_COUNT_LSB] != 16'h0000; // [RULE_08]
    end else if (boot_done & timer_running & ~timer_fire) begin
      timer_count <= 16'h0000; // [RULE_15]
      remain <= 16'h0000;
      timer_running <= 1'b0;
    end else if (timer_fire) begin
      if (auto_reload) begin
        remain <= timer_count; // [RULE_07]
      end else begin
        remain <= 16'h0000; // [RULE_07]
        timer_running <= 1'b0;
      end
    end else if (timer_running & millisecond_tick) begin
      remain <= remain - 16'h0001; // [RULE_09]
    end
  end

  // Event pulses; each expiry raises one, reload or not
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_abort <= 1'b0;
      byte_timeout_event <= 1'b0;
      transaction_timeout_event <= 1'b0;
      general_timer_expired_event <= 1'b0;
      boot_load_expired_event <= 1'b0;
    end else begin
      i2c_abort <= byte_expired | tran_expired; // [RULE_16]
      byte_timeout_event <= byte_expired;
      transaction_timeout_event <= tran_expired;
      general_timer_expired_event <=
        timer_fire & ~boot_active; // [RULE_12] [RULE_13]
      boot_load_expired_event <= timer_fire & boot_active; // [RULE_12]
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  wire [`ITB_ST_FLAGS-1:0] flag_set = {boot_load_expired_event,
                                       general_timer_expired_event,
                                       transaction_timeout_event,
                                       byte_timeout_event};
  genvar gi;
  generate
    for (gi = 0; gi < `ITB_ST_FLAGS; gi = gi + 1) begin : g_flag
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sticky[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          sticky[gi] <= 1'b1; // [RULE_16]
        end else if (wr & hit_status & pwdata[gi]) begin
          sticky[gi] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // itb_top

// ---- verif/itb_props.sv ----
// Checker for the I2C timeout and boot timer ports
`include "itb_defs.vh"
module itb_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire [`ITB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire boot_active,
  input wire boot_done,
  input wire i2c_abort,
  input wire byte_timeout_event,
  input wire transaction_timeout_event,
  input wire general_timer_expired_event,
  input wire boot_load_expired_event,
  input wire timer_running
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write to the timer register
  sequence s_tw;
    psel && penable && pready && pwrite && paddr == `ITB_OFF_TIMER;
  endsequence
  sequence s_quiet;
    !general_timer_expired_event && !boot_load_expired_event;
  endsequence
  AST_ABORT_ON_EXPIRY: assert property (
    byte_timeout_event || transaction_timeout_event |-> i2c_abort)
    else $error("no abort at expiry");
  AST_ABORT_CAUSE: assert property (
    i2c_abort |-> byte_timeout_event || transaction_timeout_event)
    else $error("abort without expiry");
  AST_BOOT_QUIET: assert property (
    boot_active && $past(boot_active) |->
    !byte_timeout_event && !transaction_timeout_event)
    else $error("watchdog active in boot load");
  AST_GEN_NOT_BOOT: assert property (
    general_timer_expired_event |-> !$past(boot_active))
    else $error("general event in boot load");
  AST_BOOT_EVT: assert property (
    boot_load_expired_event |-> $past(boot_active))
    else $error("boot event outside boot load");
  AST_WRITE_START: assert property (
    s_tw ##0 pwdata[15:0] != 16'h0 |=> timer_running ##0 s_quiet)
    else $error("write did not restart timer");
  AST_WRITE_ZERO: assert property (
    s_tw ##0 pwdata[15:0] == 16'h0 |=> !timer_running ##1 s_quiet)
    else $error("zero count left timer on");
  AST_BOOT_DONE_CLEAR: assert property (
    boot_done && timer_running && !psel |=>
    !timer_running || boot_load_expired_event ||
    general_timer_expired_event)
    else $error("boot done did not stop timer");
endmodule // itb_props

bind itb_top itb_props u_props (.*);

// ---- verif/itb_i2c_peer.sv ----
// Behavioural I2C engine and slave stand-in making bus condition pulses
module itb_i2c_peer (
  input wire pclk,
  input wire go,
  input wire [3:0] nbytes,
  input wire [9:0] gap,
  output logic i2c_start = 1'b0,
  output logic i2c_ack = 1'b0,
  output logic i2c_stop = 1'b0,
  output logic busy = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // Start, an ack per byte after gap cycles, stop; gap sets slowness
  always @(posedge pclk) if (go) begin
    busy <= 1'b1;
    i2c_start <= 1'b1;
    @(posedge pclk) i2c_start <= 1'b0;
    repeat (nbytes) begin
      repeat (gap) @(posedge pclk);
      i2c_ack <= 1'b1;
      @(posedge pclk) i2c_ack <= 1'b0;
    end
    repeat (gap) @(posedge pclk);
    i2c_stop <= 1'b1;
    @(posedge pclk) i2c_stop <= 1'b0;
    busy <= 1'b0;
  end
endmodule // itb_i2c_peer

// ---- verif/tb.sv ----
// Self-checking bench for the I2C timeout and boot timer block
`include "itb_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [16:0] paddr = 17'h0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ev, boot_active = 1, boot_done = 0, go = 0;
  logic st, ak, sp, bte, tte, gte, ble, run, busy, rs = 0;
  logic [3:0] nbytes = 4'h0;
  logic [9:0] gap = 10'h0;
  int n_errors = 0, checked = 0, nb = 0, nt = 0, ng = 0, nl = 0, c, k;

  always #12.5 pclk = ~pclk;
  // Tally one-cycle event pulses
  always @(posedge pclk) begin
    nb += bte;
    nt += tte;
    ng += gte;
    nl += ble;
  end

  itb_top #(.MS_TICKS(16'h0002)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i2c_start(st), .i2c_restart(rs), .i2c_ack(ak), .i2c_stop(sp),
    .boot_active(boot_active), .boot_done(boot_done), .i2c_abort(),
    .byte_timeout_event(bte), .transaction_timeout_event(tte),
    .general_timer_expired_event(gte), .boot_load_expired_event(ble),
    .timer_running(run));
  itb_i2c_peer peer (.pclk(pclk), .go(go), .nbytes(nbytes), .gap(gap),
    .i2c_start(st), .i2c_ack(ak), .i2c_stop(sp), .busy(busy));

  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, no assumed latency
  task automatic apb(input logic w, input logic [16:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [16:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xfer(input logic [3:0] b, input logic [9:0] g);
    @(posedge pclk);
    nbytes <= b;
    gap <= g;
    go <= 1;
    @(posedge pclk) go <= 0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
  endtask

  task automatic t_boot;
    chk(run, 1);
    rd(`ITB_OFF_TIMER, 32'h00000fa0);
    rd(`ITB_OFF_TIMEOUT, 32'h0);
    rd(17'h1d3b8, 32'h0);
    chk(ev, 1);
    apb(1, `ITB_OFF_TIMEOUT, 32'h00020001);
    xfer(4'h1, 10'h096);
    chk(nb + nt, 0);
    @(posedge pclk) boot_done <= 1;
    @(posedge pclk) boot_done <= 0;
    boot_active <= 0;
    wt(2);
    chk(run, 0);
    rd(`ITB_OFF_TIMER, 32'h0);
    @(posedge pclk) boot_active <= 1;
    apb(1, `ITB_OFF_TIMER, 32'h2);
    wt(200);
    chk(nl, 1);
    chk(ng, 0);
    @(posedge pclk) boot_active <= 0;
    $display("boot test done");
  endtask

  task automatic t_wdog;
    apb(1, `ITB_OFF_TIMEOUT, 32'h00020000);
    xfer(4'h3, 10'h014);
    chk(nb, 0);
    xfer(4'h1, 10'h078);
    chk(nb, 2);
    rd(`ITB_OFF_STATUS, 32'h00000009);
    apb(1, `ITB_OFF_STATUS, 32'h0000000f);
    rd(`ITB_OFF_STATUS, 32'h00000000);
    apb(1, `ITB_OFF_TIMEOUT, 32'h00000003);
    xfer(4'h4, 10'h014);
    chk(nt, 0);
    xfer(4'h2, 10'h096);
    chk(nt, 1);
    chk(nb, 2);
    apb(1, `ITB_OFF_TIMEOUT, 32'h0);
    xfer(4'h1, 10'h12c);
    chk(nt, 1);
    // A lone repeated start must arm the byte watchdog
    apb(1, `ITB_OFF_TIMEOUT, 32'h00020000);
    @(posedge pclk) rs <= 1;
    @(posedge pclk) rs <= 0;
    wt(120);
    chk(nb, 3);
    $display("watchdog test done");
  endtask

  task automatic t_timer;
    apb(1, `ITB_OFF_TIMER, 32'h2);
    c = 0;
    while (ng == 0 && c < 400) begin
      @(posedge pclk);
      c++;
    end
    chk(c >= 80 && c <= 170, 1);
    wt(200);
    chk(ng, 1);
    chk(run, 0);
    apb(1, `ITB_OFF_TIMER, 32'h80000001);
    wt(400);
    chk(ng >= 5, 1);
    chk(run, 1);
    apb(1, `ITB_OFF_TIMER, 32'h7fff0003);
    rd(`ITB_OFF_TIMER, 32'h00000003);
    k = ng;
    repeat (4) begin
      wt(90);
      apb(1, `ITB_OFF_TIMER, 32'h3);
    end
    wt(90);
    chk(ng, k);
    apb(1, `ITB_OFF_TIMER, 32'h0);
    wt(300);
    chk(run, 0);
    chk(ng, k);
    rd(`ITB_OFF_REMAIN, 32'h00000000);
    $display("timer test done");
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence after 20 cycles of reset
  initial begin
    wt(20);
    presetn <= 1;
    t_boot;
    t_wdog;
    t_timer;
    give_verdict;
  end
  // Watchdog far beyond the expected few thousand cycles
  initial begin
    #1000000;
    n_errors++;
    give_verdict;
  end
endmodule // tb
